// [tcm_pkg.sv]
// Shared constants for the triple channel monitor
package tcm_pkg;

   // Register indices on the plain register port
   localparam logic [7:0] ADDR_CONFIG    = 8'h00;
   localparam logic [7:0] ADDR_SHUNT1    = 8'h01;
   localparam logic [7:0] ADDR_LAST_RES  = 8'h06;
   localparam logic [7:0] ADDR_CRIT1     = 8'h07;
   localparam logic [7:0] ADDR_LAST_LIM  = 8'h0c;
   localparam logic [7:0] ADDR_SUM       = 8'h0d;
   localparam logic [7:0] ADDR_SUM_LIMIT = 8'h0e;
   localparam logic [7:0] ADDR_MASK_EN   = 8'h0f;
   localparam logic [7:0] ADDR_STATUS    = 8'h10;

   // Configuration fields
   localparam int         CFG_EN_LSB   = 12;
   localparam int         CFG_AVG_LSB  = 9;
   localparam logic [15:0] CFG_RESET   = 16'h7007;
   localparam logic [15:0] CFG_WMASK   = 16'h7e07;

   // Mask/enable fields
   localparam int         ME_SCC_LSB   = 12;
   localparam int         ME_SF_BIT    = 11;
   localparam int         ME_CF_LSB    = 8;
   localparam int         ME_WF_LSB    = 4;
   localparam int         ME_CONVERSION_READY_FLAG_BIT  = 0;

   // Result and limit layout
   localparam int         RES_LSB      = 3;
   localparam logic [15:0] LIMIT_RESET = 16'h7ff8;
   localparam logic [15:0] SUM_LIM_RESET = 16'h7ffe;
   localparam int         FRAC_BITS    = 10;

   // Timing
   localparam int         CLK_PERIOD_PS   = 5000;
   localparam int         RECOVERY_US     = 40;
   localparam int         SCL_TIMEOUT_MS  = 28;
   localparam int         RECOVERY_CYCLES =
      (RECOVERY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int         SCL_TIMEOUT_CYCLES =
      (SCL_TIMEOUT_MS * 1000000) / CLK_PERIOD_PS * 1000;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_DOWN,
      ST_RECOVER,
      ST_PICK,
      ST_CONV
   } seq_state_t;

endpackage

// [triple_channel_monitor_alerts.sv]
// Conversion sequencer, result registers and alert logic of the monitor
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

//Behaviour
//- Three-bit mode field selects measurements, applied alike to every channel.
//- Mode 111 converts each channel's shunt first, then its bus voltage.
//- Step to next enabled channel after each one; skip disabled channels always.
//- Continuous modes repeat the pass until a new configuration is written.
//- Single-shot codes 001/010/011 run one pass then power down.
//- Every configuration write is a fresh trigger, even with unchanged mode.
//- Result registers readable anytime; bus holds last completed conversion, shunt its average.
//- Conversion-ready flag sets once all conversions of the pass finish.
//- Ready flag clears on mask/enable read or non-power-down config write.
//- Power-down accepts register access and holds until an active mode.
//- Leaving power-down waits a 40 us recovery before converting.
//- Four alerts are open-drain, pulled low to assert; power-good is held low always, sequencing-check never.
//- Each shunt conversion compared to its critical limit; excess pulls critical low.
//- Critical limits reset to positive full scale.
//- Channel exceeding its critical limit sets its critical flag.
//- Selected shunt conversions (any of the three, one or more) summed into sum register.
//- Sum of two or three channels above sum limit pulls critical low and sets summation flag.
//- Shunt register holds average over chosen count, updated every conversion.
//- Averaged shunt above warning limit pulls warning low, sets warning flag.
//- Warning limits reset to positive full scale.
//- Bus result uses fixed 8 mV per bit, full scale 32.76 V.
//- Serial interface resets when clock line stays low beyond 28 ms.
module triple_channel_monitor_alerts #(
   parameter int RECOVERY_CYC    = tcm_pkg::RECOVERY_CYCLES,
   parameter int SCL_TIMEOUT_CYC = tcm_pkg::SCL_TIMEOUT_CYCLES
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   input  wire logic [7:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   output logic             o_adc_start,
   output logic             o_adc_abort,
   output logic      [1:0]  o_adc_channel,
   output logic             o_adc_bus_sel,
   input  wire logic        i_adc_done,
   input  wire logic [12:0] i_adc_data,
   input  wire logic        i_scl,
   output logic             o_serial_reset,
   output logic             o_critical_out,
   output logic             o_critical_oe_n,
   output logic             o_warning_out,
   output logic             o_warning_oe_n,
   output logic             o_power_good_output_out,
   output logic             o_power_good_output_oe_n,
   output logic             o_sequencing_check_output_out,
   output logic             o_sequencing_check_output_oe_n
);
   import tcm_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   seq_state_t         state_q;
   logic [15:0]        config_q;
   logic [2:0]         summation_channel_select;
   logic               conversion_ready_flag;
   logic [2:0]         channel_critical_flags;
   logic [2:0]         channel_warning_flags;
   logic               summation_alert_flag;
   logic [15:0]        crit_lim_q [3];
   logic [15:0]        warn_lim_q [3];
   logic [15:0]        sum_lim_q;
   logic [15:0]        bus_res_q  [3];
   logic signed [12:0] raw_q      [3];
   logic signed [22:0] avg_q      [3];
   logic [1:0]         ch_q;
   logic               is_bus_q;
   logic [31:0]        rec_cnt_q;
   logic               pass_end;
   logic               cfg_wr;
   logic [2:0]         mode;
   logic [2:0]         chan_en;
   logic [3:0]         avg_shift;
   logic               conv_done;
   logic signed [22:0] avg_next;
   logic signed [14:0] sum_val;
   logic [15:0]        sum_reg;
   logic               sum_active;
   logic [15:0]        shunt_reg  [3];
   logic [1:0]         scl_sync_q;
   logic [31:0]        scl_cnt_q;

   assign cfg_wr    = i_wr && (i_addr == ADDR_CONFIG);
   assign mode      = config_q[2:0];
   assign chan_en   = config_q[CFG_EN_LSB +: 3];
   assign conv_done = (state_q == ST_CONV) && i_adc_done;
   assign pass_end  = (state_q == ST_PICK) && (ch_q == 2'd3);

   always_comb
   begin
      unique case (config_q[CFG_AVG_LSB +: 3])
         3'h0:    avg_shift = 4'h0;
         3'h1:    avg_shift = 4'h2;
         3'h2:    avg_shift = 4'h4;
         3'h3:    avg_shift = 4'h6;
         3'h4:    avg_shift = 4'h7;
         3'h5:    avg_shift = 4'h8;
         3'h6:    avg_shift = 4'h9;
         default: avg_shift = 4'ha;
      endcase
   end

   // ****************************************
   // Configuration and limit registers
   // ****************************************
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         config_q                 <= CFG_RESET;
         summation_channel_select <= 3'h0;
         sum_lim_q                <= SUM_LIM_RESET;
         for (int i = 0; i < 3; i++)
         begin
            crit_lim_q[i] <= LIMIT_RESET;
            warn_lim_q[i] <= LIMIT_RESET;
         end
      end
      else if (i_wr)
      begin
         if (cfg_wr)
            config_q <= i_wdata & CFG_WMASK;
         if (i_addr == ADDR_MASK_EN)
            summation_channel_select <= i_wdata[ME_SCC_LSB +: 3];
         if (i_addr == ADDR_SUM_LIMIT)
            sum_lim_q <= {i_wdata[15:1], 1'b0};
         for (int i = 0; i < 3; i++)
         begin
            if (i_addr == ADDR_CRIT1 + 8'(2 * i))
               crit_lim_q[i] <= {i_wdata[15:RES_LSB], 3'h0};
            if (i_addr == ADDR_CRIT1 + 8'(2 * i + 1))
               warn_lim_q[i] <= {i_wdata[15:RES_LSB], 3'h0};
         end
      end
   end

   // ****************************************
   // Conversion sequencer
   // ****************************************
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         state_q   <= ST_PICK;
         ch_q      <= 2'd0;
         is_bus_q  <= 1'b0;
         rec_cnt_q <= 32'h0;
      end
      else if (cfg_wr)
      begin
         // A new value aborts the pass and restarts at channel 1
         ch_q      <= 2'd0;
         rec_cnt_q <= 32'h0;
         if (i_wdata[1:0] == 2'b00)
            state_q <= ST_DOWN;
         else if (state_q == ST_DOWN || state_q == ST_RECOVER)
            state_q <= ST_RECOVER;
         else
            state_q <= ST_PICK;
      end
      else
      begin
         unique case (state_q)
            ST_DOWN:
               state_q <= ST_DOWN;
            ST_RECOVER:
            begin
               rec_cnt_q <= rec_cnt_q + 32'h1;
               if (rec_cnt_q >= 32'(RECOVERY_CYC - 1))
                  state_q <= ST_PICK;
            end
            ST_PICK:
            begin
               if (ch_q == 2'd3)
               begin
                  ch_q <= 2'd0;
                  state_q <= mode[2] ? ST_PICK : ST_DOWN;
               end
               else if (!chan_en[ch_q])
                  ch_q <= ch_q + 2'd1;
               else
               begin
                  is_bus_q <= !mode[0];
                  state_q  <= ST_CONV;
               end
            end
            ST_CONV:
            begin
               if (i_adc_done)
               begin
                  if (!is_bus_q && mode[1])
                  begin
                     is_bus_q <= 1'b1;
                     state_q  <= ST_CONV;
                  end
                  else
                  begin
                     ch_q    <= ch_q + 2'd1;
                     state_q <= ST_PICK;
                  end
               end
            end
            default:
               state_q <= ST_DOWN;
         endcase
      end
   end

   // Start pulse on entry to each conversion
   always_comb
   begin
      o_adc_start = 1'b0;
      if (!cfg_wr)
      begin
         if (state_q == ST_PICK && ch_q != 2'd3 && chan_en[ch_q])
            o_adc_start = 1'b1;
         if (conv_done && !is_bus_q && mode[1])
            o_adc_start = 1'b1;
      end
   end
   assign o_adc_abort   = cfg_wr && (state_q == ST_CONV);
   assign o_adc_channel = ch_q;
   assign o_adc_bus_sel = (state_q == ST_PICK) ? !mode[0] : (is_bus_q || conv_done);

   // ****************************************
   // Results, averaging and sum
   // ****************************************
   always_comb
   begin
      avg_next = 23'sh0;
      if (ch_q != 2'd3)
         avg_next = avg_q[ch_q] +
            (((23'($signed(i_adc_data)) <<< FRAC_BITS) - avg_q[ch_q]) >>> avg_shift);
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < 3; i++)
         begin
            raw_q[i]     <= 13'sh0;
            avg_q[i]     <= 23'sh0;
            bus_res_q[i] <= 16'h0;
         end
      end
      else if (conv_done && ch_q != 2'd3)
      begin
         if (is_bus_q)
            bus_res_q[ch_q] <= {i_adc_data, 3'h0};
         else
         begin
            raw_q[ch_q] <= $signed(i_adc_data);
            avg_q[ch_q] <= avg_next;
         end
      end
   end

   always_comb
   begin
      sum_val = 15'sh0;
      for (int i = 0; i < 3; i++)
      begin
         shunt_reg[i] = {avg_q[i][22:FRAC_BITS], 3'h0};
         if (summation_channel_select[i])
            sum_val = sum_val + 15'(raw_q[i]);
      end
   end
   assign sum_reg    = {sum_val, 1'b0};
   assign sum_active = (summation_channel_select == 3'b011) ||
                       (summation_channel_select == 3'b101) ||
                       (summation_channel_select == 3'b110) ||
                       (summation_channel_select == 3'b111);

   // ****************************************
   // Flags
   // ****************************************
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         channel_critical_flags <= 3'h0;
         channel_warning_flags  <= 3'h0;
         summation_alert_flag   <= 1'b0;
      end
      else
      begin
         summation_alert_flag <= sum_active &&
            ($signed(sum_reg) > $signed(sum_lim_q));
         if (conv_done && !is_bus_q && ch_q != 2'd3)
         begin
            channel_critical_flags[ch_q] <=
               $signed({i_adc_data, 3'h0}) > $signed(crit_lim_q[ch_q]);
            channel_warning_flags[ch_q] <=
               $signed({avg_next[22:FRAC_BITS], 3'h0}) >
               $signed(warn_lim_q[ch_q]);
         end
      end
   end

   // Setting at pass end wins over a clear in the same cycle
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         conversion_ready_flag <= 1'b0;
      else if (pass_end)
         conversion_ready_flag <= 1'b1;
      else if ((i_rd && i_addr == ADDR_MASK_EN) ||
               (cfg_wr && i_wdata[1:0] != 2'b00))
         conversion_ready_flag <= 1'b0;
   end

   // ****************************************
   // Open-drain alerts
   // ****************************************
   assign o_critical_out  = 1'b0;
   assign o_critical_oe_n = !(|channel_critical_flags || summation_alert_flag);
   assign o_warning_out   = 1'b0;
   assign o_warning_oe_n  = !(|channel_warning_flags);
   assign o_power_good_output_out       = 1'b0;
   assign o_power_good_output_oe_n      = 1'b0;
   assign o_sequencing_check_output_out = 1'b0;
   assign o_sequencing_check_output_oe_n = 1'b1;

   // ****************************************
   // Serial clock low timeout
   // ****************************************
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         scl_sync_q <= 2'b11;
      else
         scl_sync_q <= {scl_sync_q[0], i_scl};
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         scl_cnt_q      <= 32'h0;
         o_serial_reset <= 1'b0;
      end
      else
      begin
         o_serial_reset <= 1'b0;
         if (scl_sync_q[1])
            scl_cnt_q <= 32'h0;
         else if (scl_cnt_q < 32'(SCL_TIMEOUT_CYC))
         begin
            scl_cnt_q <= scl_cnt_q + 32'h1;
            if (scl_cnt_q == 32'(SCL_TIMEOUT_CYC - 1))
               o_serial_reset <= 1'b1;
         end
      end
   end

   // ****************************************
   // Register read port
   // ****************************************
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         o_rdata <= 16'h0;
      else if (i_rd)
      begin
         o_rdata <= 16'h0;
         if (i_addr == ADDR_CONFIG)
            o_rdata <= config_q;
         if (i_addr >= ADDR_SHUNT1 && i_addr <= ADDR_LAST_RES)
            o_rdata <= i_addr[0] ? shunt_reg[2'((i_addr - ADDR_SHUNT1) >> 1)]
                                 : bus_res_q[2'((i_addr - ADDR_SHUNT1) >> 1)];
         if (i_addr >= ADDR_CRIT1 && i_addr <= ADDR_LAST_LIM)
            o_rdata <= i_addr[0] ? crit_lim_q[2'((i_addr - ADDR_CRIT1) >> 1)]
                                 : warn_lim_q[2'((i_addr - ADDR_CRIT1) >> 1)];
         if (i_addr == ADDR_SUM)
            o_rdata <= sum_reg;
         if (i_addr == ADDR_SUM_LIMIT)
            o_rdata <= sum_lim_q;
         if (i_addr == ADDR_MASK_EN)
         begin
            o_rdata[ME_SCC_LSB +: 3] <= summation_channel_select;
            o_rdata[ME_SF_BIT]       <= summation_alert_flag;
            o_rdata[ME_CF_LSB +: 3]  <= channel_critical_flags;
            o_rdata[ME_WF_LSB +: 3]  <= channel_warning_flags;
            o_rdata[ME_CONVERSION_READY_FLAG_BIT]     <= conversion_ready_flag;
         end
         if (i_addr == ADDR_STATUS)
            o_rdata <= {13'h0, state_q == ST_DOWN, state_q == ST_RECOVER,
                        state_q == ST_CONV};
      end
   end

endmodule
`default_nettype wire

// [tcm_monitor.sv]
// Port-level assertions for the triple channel monitor
`timescale 1ns/10ps
`default_nettype none
module tcm_monitor
   import tcm_pkg::*;
#(
   parameter int SCL_TIMEOUT_CYC = SCL_TIMEOUT_CYCLES
) (
   input wire logic        i_core_clk,
   input wire logic        i_rst_n,
   input wire logic [7:0]  i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic        o_adc_start,
   input wire logic        o_adc_abort,
   input wire logic [1:0]  o_adc_channel,
   input wire logic        o_adc_bus_sel,
   input wire logic        i_adc_done,
   input wire logic        i_scl,
   input wire logic        o_serial_reset,
   input wire logic        o_critical_out,
   input wire logic        o_warning_out,
   input wire logic        o_power_good_output_oe_n,
   input wire logic        o_sequencing_check_output_oe_n
);
   // ******
   // Helper state
   // ******
   logic [2:0] mode_q;
   logic [1:0] ch_q;
   logic       bus_q;
   logic       pend_q;
   int         low_q;

   always_ff @(posedge i_core_clk)
      if (!i_rst_n)
         mode_q <= 3'h7;
      else if (i_wr && i_addr == ADDR_CONFIG)
         mode_q <= i_wdata[2:0];

   always_ff @(posedge i_core_clk)
      if (!i_rst_n)
         bus_q <= 1'h1;
      else if (o_adc_start)
      begin
         ch_q  <= o_adc_channel;
         bus_q <= o_adc_bus_sel;
      end

   always_ff @(posedge i_core_clk)
      if (!i_rst_n)
         pend_q <= 1'h0;
      else if (o_adc_start)
         pend_q <= 1'h1;
      else if (i_adc_done || o_adc_abort)
         pend_q <= 1'h0;

   // Raw low time of the serial clock, saturating
   always_ff @(posedge i_core_clk)
      if (!i_rst_n || i_scl)
         low_q <= 0;
      else if (low_q <= SCL_TIMEOUT_CYC)
         low_q <= low_q + 1;

   // ******
   // Properties
   // ******
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   property p_open_drain;
      !o_critical_out && !o_warning_out && !o_power_good_output_oe_n
         && o_sequencing_check_output_oe_n;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("alert pin not open drain");

   property p_shunt_first;
      o_adc_start && o_adc_bus_sel && mode_q == 3'h7 |-> ch_q == o_adc_channel && !bus_q;
   endproperty
   a_shunt_first: assert property (p_shunt_first) else $error("bus before its shunt");

   property p_mode_kind;
      o_adc_start && mode_q[1:0] != 2'h3 |-> o_adc_bus_sel == mode_q[1];
   endproperty
   a_mode_kind: assert property (p_mode_kind) else $error("wrong measurement kind");

   property p_no_sentinel;
      o_adc_start |-> o_adc_channel != 2'h3;
   endproperty
   a_no_sentinel: assert property (p_no_sentinel) else $error("start on unused channel");

   property p_one_pending;
      o_adc_start |-> !pend_q || i_adc_done || o_adc_abort;
   endproperty
   a_one_pending: assert property (p_one_pending) else $error("second conversion started");

   property p_abort_cause;
      o_adc_abort |-> i_wr && i_addr == ADDR_CONFIG && pend_q;
   endproperty
   a_abort_cause: assert property (p_abort_cause) else $error("abort without config write");

   property p_pd_quiet;
      i_wr && i_addr == ADDR_CONFIG && i_wdata[1:0] == 2'h0 |=> !o_adc_start [*8];
   endproperty
   a_pd_quiet: assert property (p_pd_quiet) else $error("conversion while powered down");

   property p_rd_hold;
      $past(i_rst_n) && !$past(i_rd) |-> $stable(o_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");

   property p_scl_reset;
      o_serial_reset |-> low_q >= SCL_TIMEOUT_CYC ##1 !o_serial_reset;
   endproperty
   a_scl_reset: assert property (p_scl_reset) else $error("serial reset early or long");

   c_abort: cover property (o_adc_abort);
   c_bus: cover property (o_adc_start && o_adc_bus_sel);
   c_scl: cover property (o_serial_reset);
endmodule
`default_nettype wire

// [adc_model.sv]
// Behavioural converter answering the monitor's conversion requests
`timescale 1ns/10ps
`default_nettype none
module adc_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_start,
   input  wire logic        i_abort,
   input  wire logic [1:0]  i_channel,
   input  wire logic        i_bus_sel,
   output logic             o_done = 1'h0,
   output logic      [12:0] o_data = 13'h0aaa
);
   logic [12:0] shunt_v [3];
   logic [12:0] bus_v [3];
   logic [2:0]  seen = 3'h0;
   logic [1:0]  ch;
   logic        sel;
   logic        busy = 1'h0;
   int          lat = 1;
   int          cnt;
   int          n_start = 0;
   int          n_bus = 0;
   int          n_abort = 0;

   // ******
   // Conversion engine
   // ******
   always @(posedge i_core_clk)
   begin
      o_done <= 1'h0;
      // Data line toggles outside done so stale values never look valid
      o_data <= ~o_data;
      if (!i_rst_n || i_abort)
         busy = 1'h0;
      if (i_abort)
         n_abort++;
      if (busy && cnt > 1)
         cnt--;
      else if (busy)
      begin
         o_done <= 1'h1;
         o_data <= sel ? bus_v[ch] : shunt_v[ch];
         busy = 1'h0;
      end
      if (i_start && i_rst_n)
      begin
         busy = 1'h1;
         cnt = lat;
         ch = i_channel;
         sel = i_bus_sel;
         n_start++;
         n_bus += int'(i_bus_sel);
         seen[i_channel] = 1'h1;
      end
   end
endmodule
`default_nettype wire

// [triple_channel_monitor_alerts_test.sv]
// Self-checking bench for the triple channel monitor
`timescale 1ns/10ps
`default_nettype none
module triple_channel_monitor_alerts_test;
   import tcm_pkg::*;
   localparam int RC = 10;
   localparam int SCL_TIMEOUT_CYC = 50;
   logic        i_core_clk = 1'h0;
   logic        i_rst_n = 1'h0;
   logic        i_wr = 1'h0;
   logic        i_rd = 1'h0;
   logic        i_scl = 1'h1;
   logic [7:0]  i_addr = 8'h0;
   logic [15:0] i_wdata = 16'h0;
   logic [15:0] o_rdata;
   logic [15:0] v;
   logic        o_adc_start, o_adc_abort, o_adc_bus_sel, i_adc_done, o_serial_reset;
   logic [1:0]  o_adc_channel;
   logic [12:0] i_adc_data;
   logic        o_critical_out, o_critical_oe_n, o_warning_out, o_warning_oe_n;
   logic        o_power_good_output_out, o_power_good_output_oe_n;
   logic        o_sequencing_check_output_out, o_sequencing_check_output_oe_n;
   logic        scl_low = 1'h0;
   logic        sr_seen = 1'h0;
   int          bad_count = 0;
   int          tests_run = 0;
   int          n0, b0, k, md;

   triple_channel_monitor_alerts #(.RECOVERY_CYC(RC), .SCL_TIMEOUT_CYC(SCL_TIMEOUT_CYC)) uut (.*);
   adc_model adc (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_start(o_adc_start),
      .i_abort(o_adc_abort), .i_channel(o_adc_channel), .i_bus_sel(o_adc_bus_sel),
      .o_done(i_adc_done), .o_data(i_adc_data));

   initial forever #2.5 i_core_clk = ~i_core_clk;
   // Serial clock of 80 ns, held low on request
   initial
   begin
      #1.3;
      forever #40 i_scl = scl_low ? 1'h0 : ~i_scl;
   end
   always @(posedge i_core_clk) if (o_serial_reset) sr_seen <= 1'h1;

   // ******
   // Access and check tasks
   // ******
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      i_wr <= 1'h1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'h0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge i_core_clk);
      i_rd <= 1'h1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'h0;
      #1 d = o_rdata;
   endtask
   task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic wait_n(input int n);
      int j;
      j = 0;
      while (adc.n_start < n && j < 3000)
      begin
         @(posedge i_core_clk);
         j++;
      end
      chk("starts", 16'(adc.n_start >= n), 16'h1);
   endtask
   task automatic pd_wait;
      int j;
      j = 0;
      v = 16'h0;
      while (v[2:0] !== 3'h4 && j < 400)
      begin
         rd(ADDR_STATUS, v);
         j++;
      end
      chk("down", 16'(v[2:0]), 16'h4);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      #100000;
      bad_count++;
      conclude;
   end

   // ******
   // Test sequence
   // ******
   initial
   begin
      for (k = 0; k < 3; k++)
      begin
         adc.shunt_v[k] = 13'(100 * (k + 1));
         adc.bus_v[k] = (k == 2) ? 13'h0fff : 13'h05dc;
      end
      repeat (5) @(posedge i_core_clk);
      i_rst_n <= 1'h1;
      rd(ADDR_CONFIG, v);
      chk("config", v, CFG_RESET);
      for (k = 0; k < 6; k++)
      begin
         rd(ADDR_CRIT1 + 8'(k), v);
         chk("limit", v, LIMIT_RESET);
      end
      rd(ADDR_SUM_LIMIT, v);
      chk("sum limit", v, SUM_LIM_RESET);
      rd(8'h20, v);
      chk("unmapped", v, 16'h0);
      chk("crit idle", 16'(o_critical_oe_n), 16'h1);
      chk("warn idle", 16'(o_warning_oe_n), 16'h1);
      wait_n(adc.n_start + 12);
      for (k = 0; k < 3; k++)
      begin
         rd(ADDR_SHUNT1 + 8'(2 * k), v);
         chk("shunt", v, 16'(adc.shunt_v[k]) << 3);
         rd(ADDR_SHUNT1 + 8'(2 * k + 1), v);
         chk("bus", v, (k == 2) ? 16'h7ff8 : 16'h2ee0);
      end
      wr(ADDR_CRIT1, 16'h0008);
      wr(ADDR_CRIT1 + 8'h1, 16'h0008);
      wait_n(adc.n_start + 14);
      chk("crit pin", 16'(o_critical_oe_n), 16'h0);
      chk("warn pin", 16'(o_warning_oe_n), 16'h0);
      rd(ADDR_MASK_EN, v);
      chk("crit flags", 16'($countones(v[10:8])), 16'h1);
      chk("warn flags", 16'($countones(v[6:4])), 16'h1);
      wr(ADDR_CRIT1, LIMIT_RESET);
      wr(ADDR_CRIT1 + 8'h1, LIMIT_RESET);
      wr(ADDR_MASK_EN, 16'h7000);
      wr(ADDR_SUM_LIMIT, 16'h0002);
      wait_n(adc.n_start + 14);
      rd(ADDR_SUM, v);
      chk("sum", v, 16'h04b0);
      rd(ADDR_MASK_EN, v);
      chk("sum flag", v & 16'hff00, 16'h7800);
      chk("sum pin", 16'(o_critical_oe_n), 16'h0);
      wr(ADDR_MASK_EN, 16'h0000);
      wait_n(adc.n_start + 14);
      chk("sum off", 16'(o_critical_oe_n), 16'h1);
      wr(ADDR_CONFIG, 16'h5007);
      wait_n(adc.n_start + 2);
      adc.seen = 3'h0;
      wait_n(adc.n_start + 8);
      chk("channels", 16'(adc.seen), 16'h5);
      adc.lat = 30;
      wait_n(adc.n_start + 1);
      n0 = adc.n_abort;
      wr(ADDR_CONFIG, 16'h7007);
      chk("abort", 16'(adc.n_abort - n0), 16'h1);
      adc.lat = 1;
      // Single-shot modes 3, 3 again, 1 and 2
      for (k = 0; k < 4; k++)
      begin
         md = (k < 2) ? 3 : k - 1;
         wr(ADDR_CONFIG, 16'h7000 | 16'(md));
         n0 = adc.n_start;
         b0 = adc.n_bus;
         pd_wait;
         chk("shots", 16'(adc.n_start - n0), (md == 3) ? 16'h6 : 16'h3);
         chk("bus shots", 16'(adc.n_bus - b0), (md == 1) ? 16'h0 : 16'h3);
         rd(ADDR_MASK_EN, v);
         chk("ready set", 16'(v[0]), 16'h1);
         rd(ADDR_MASK_EN, v);
         chk("ready read", 16'(v[0]), 16'h0);
      end
      wr(ADDR_CONFIG, 16'h7001);
      pd_wait;
      wr(ADDR_CONFIG, 16'h7000);
      rd(ADDR_MASK_EN, v);
      chk("ready pd", 16'(v[0]), 16'h1);
      wr(ADDR_CRIT1, 16'h1230);
      rd(ADDR_CRIT1, v);
      chk("pd access", v, 16'h1230);
      n0 = adc.n_start;
      repeat (20) @(posedge i_core_clk);
      chk("pd idle", 16'(adc.n_start - n0), 16'h0);
      wr(ADDR_CONFIG, 16'h7001);
      rd(ADDR_MASK_EN, v);
      chk("ready cfg", 16'(v[0]), 16'h0);
      k = 0;
      while (adc.n_start == n0 && k < 1000)
      begin
         @(posedge i_core_clk);
         k++;
      end
      chk("recovery", 16'(k + 3 >= RC), 16'h1);
      chk("recovered", 16'(adc.n_start != n0), 16'h1);
      chk("no scl reset", 16'(sr_seen), 16'h0);
      scl_low = 1'h1;
      repeat (SCL_TIMEOUT_CYC + 30) @(posedge i_core_clk);
      chk("scl reset", 16'(sr_seen), 16'h1);
      scl_low = 1'h0;
      conclude;
   end
endmodule

bind triple_channel_monitor_alerts tcm_monitor #(.SCL_TIMEOUT_CYC(SCL_TIMEOUT_CYC)) mon (.*);
`default_nettype wire
